//--- core/brtc_top.sv
/*
  backed-up real time clock: time and day counters, alarm, interrupt flags,
  calibration and backup regulator level select, with an apb register slave.
  assumes apb master on the same 32.768 kHz clock and the backup power-on reset.
*/
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "brtc_defs.svh"

// How it works
// - divide time base to 1 Hz tick; each tick advances 17-bit seconds counter.
// - seconds counter runs 0 to 86399, then returns to 0.
// - each seconds rollover increments 15-bit day counter.
// - each tick sets one-second flag; drives interrupt only when unmasked.
// - alarm flag set when seconds and day both equal alarm values.
// - alarm match powers up when off; otherwise only interrupts.
// - disable bit stops the clock; resets to 0 so clock runs.
// - backup reset clears time, day, alarm and control; sets reset flag and all masks.
// - after backup reset the timer-reset flag is set.
// - 5-bit signed word changes cycles counted per nominal second.
// - codes read as two's complement, +15 down to -16 counts.
// - calibration touches only the tick divider, never the slow clock output.
// - mode 00 off, 01 except coin cell, 11 always, 10 reserved.
// - mode 01 drops calibration while running from the coin cell.
// - backup regulator enabled from reset on, with no disable control.
// - strap 0110 to 1001 gives 1.3 V in on modes, else 1.2 V.
// - flags latch until written 1; line drops unless another unmasked flag.
// - set masks block the line; all masked at reset; unmask drives at once.
module brtc_top #(
  parameter int CYCLES = `BRTC_BASE_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] powerup_strap_code,
  input wire brtc_pkg::brtc_pwr_t power_mode,
  input wire logic slow_clock_in,
  output logic slow_clock_output,
  output logic irq,
  output logic powerup_request,
  output logic backup_domain_regulator_en,
  output logic backup_domain_regulator_high
);

  // ***********************************************************************
  // state
  // ***********************************************************************
  logic clock_disable_bit_reg;
  logic [4:0] calibration_word_reg;
  brtc_pkg::brtc_cal_mode_t calibration_mode_field_reg;
  logic [16:0] seconds_of_day_counter_reg;
  logic [14:0] day_counter_reg;
  logic [16:0] alarm_seconds_value_reg;
  logic [14:0] alarm_day_value_reg;
  logic [2:0] irq_flag_reg;
  logic [2:0] irq_mask_reg;
  logic powerup_request_reg;
  logic regulator_high_reg;
  logic [31:0] prdata_reg;
  logic tick;
  logic cal_active;
  logic wr;
  logic rd;
  logic alarm_hit;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;

  function automatic logic hit(input logic [11:0] off);
    hit = psel && penable && (paddr == off);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `BRTC_OFF_STATUS);
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  // ***********************************************************************
  // calibration enable and divider
  // ***********************************************************************
  // mode 01 falls back to none on the coin cell; reserved code acts as off
  always_comb begin
    case (calibration_mode_field_reg)
      brtc_pkg::BRTC_CAL_NOT_COIN: cal_active = (power_mode != brtc_pkg::BRTC_PWR_COIN);
      brtc_pkg::BRTC_CAL_ALWAYS: cal_active = 1'b1;
      default: cal_active = 1'b0;
    endcase
  end

  brtc_divider #(
    .CYCLES(CYCLES)
  ) u_div (
    .clock(clock),
    .reset_n(reset_n),
    .run(!clock_disable_bit_reg),
    .cal_active(cal_active),
    .calibration_word(calibration_word_reg),
    .tick(tick)
  );

  // slow clock passes straight through, calibration never reaches it
  assign slow_clock_output = slow_clock_in;

  // ***********************************************************************
  // control register
  // ***********************************************************************
  // reset clears the control register; disable bit 0 so the clock runs
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clock_disable_bit_reg <= 1'b0;
      calibration_word_reg <= 5'h00;
      calibration_mode_field_reg <= brtc_pkg::BRTC_CAL_OFF;
    end else if (wr && hit(`BRTC_OFF_CTRL)) begin
      clock_disable_bit_reg <= pwdata[`BRTC_CTRL_DIS_BIT];
      calibration_word_reg <= pwdata[`BRTC_CTRL_CAL_LSB +: 5];
      calibration_mode_field_reg <= brtc_pkg::brtc_cal_mode_t'(pwdata[`BRTC_CTRL_MODE_LSB +: 2]);
    end
  end

  // ***********************************************************************
  // time and day counters
  // ***********************************************************************
  // software write loads time; a tick in the same cycle yields to the write
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      seconds_of_day_counter_reg <= 17'h00000;
    end else if (wr && hit(`BRTC_OFF_TIME)) begin
      seconds_of_day_counter_reg <= pwdata[16:0];
    end else if (tick) begin
      if (seconds_of_day_counter_reg >= `BRTC_SEC_MAX) begin
        seconds_of_day_counter_reg <= 17'h00000;
      end else begin
        seconds_of_day_counter_reg <= seconds_of_day_counter_reg + 17'h00001;
      end
    end
  end

  // day advances on each seconds rollover, wraps past 32767
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      day_counter_reg <= 15'h0000;
    end else if (wr && hit(`BRTC_OFF_DAY)) begin
      day_counter_reg <= pwdata[14:0];
    end else if (tick && seconds_of_day_counter_reg >= `BRTC_SEC_MAX) begin
      day_counter_reg <= day_counter_reg + 15'h0001;
    end
  end

  // ***********************************************************************
  // alarm
  // ***********************************************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alarm_seconds_value_reg <= 17'h00000;
      alarm_day_value_reg <= 15'h0000;
    end else begin
      if (wr && hit(`BRTC_OFF_ALM_TIME)) begin
        alarm_seconds_value_reg <= pwdata[16:0];
      end
      if (wr && hit(`BRTC_OFF_ALM_DAY)) begin
        alarm_day_value_reg <= pwdata[14:0];
      end
    end
  end

  // match checked once per new second so one alarm gives one event
  assign alarm_hit = tick && (seconds_of_day_counter_reg == alarm_seconds_value_reg)
    && (day_counter_reg == alarm_day_value_reg);

  // off device wakes on a match; request holds until the device is on
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      powerup_request_reg <= 1'b0;
    end else if (power_mode == brtc_pkg::BRTC_PWR_ON) begin
      powerup_request_reg <= 1'b0;
    end else if (alarm_hit) begin
      powerup_request_reg <= 1'b1;
    end
  end

  assign powerup_request = powerup_request_reg;

  // ***********************************************************************
  // interrupt flags and masks
  // ***********************************************************************
  // alarm is compared before the tick moves the count, so the compare is combinational
  assign irq_set[`BRTC_IRQ_SEC_BIT] = tick;
  assign irq_set[`BRTC_IRQ_ALM_BIT] = alarm_hit;
  assign irq_set[`BRTC_IRQ_RST_BIT] = 1'b0;
  assign irq_clr = (wr && hit(`BRTC_OFF_IRQ_STAT)) ? pwdata[2:0] : 3'h0;

  // flags latch; a set in the clearing cycle wins; reset flag comes up set
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_flag_reg <= `BRTC_STAT_INIT;
    end else begin
      irq_flag_reg <= irq_set | (irq_flag_reg & ~irq_clr);
    end
  end

  // all masked at power-up
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask_reg <= `BRTC_MASK_RESET;
    end else if (wr && hit(`BRTC_OFF_IRQ_MASK)) begin
      irq_mask_reg <= pwdata[2:0];
    end
  end

  // combinational so an unmask reaches the line with no delay
  assign irq = |(irq_flag_reg & ~irq_mask_reg);

  // ***********************************************************************
  // backup regulator
  // ***********************************************************************
  // always on out of reset, nothing can turn it off
  assign backup_domain_regulator_en = 1'b1;

  // 1.3 V only for straps 0110..1001 in on modes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      regulator_high_reg <= 1'b0;
    end else begin
      regulator_high_reg <= (powerup_strap_code >= 4'h6) && (powerup_strap_code <= 4'h9)
        && (power_mode == brtc_pkg::BRTC_PWR_ON);
    end
  end

  assign backup_domain_regulator_high = regulator_high_reg;

  // ***********************************************************************
  // apb read data
  // ***********************************************************************
  // read data registered during setup so it stands at the access edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `BRTC_OFF_CTRL: prdata_reg <= {14'h0000, calibration_mode_field_reg, 3'h0,
          calibration_word_reg, 7'h00, clock_disable_bit_reg};
        `BRTC_OFF_TIME: prdata_reg <= {15'h0000, seconds_of_day_counter_reg};
        `BRTC_OFF_DAY: prdata_reg <= {17'h00000, day_counter_reg};
        `BRTC_OFF_ALM_TIME: prdata_reg <= {15'h0000, alarm_seconds_value_reg};
        `BRTC_OFF_ALM_DAY: prdata_reg <= {17'h00000, alarm_day_value_reg};
        `BRTC_OFF_IRQ_STAT: prdata_reg <= {29'h00000000, irq_flag_reg};
        `BRTC_OFF_IRQ_MASK: prdata_reg <= {29'h00000000, irq_mask_reg};
        `BRTC_OFF_STATUS: prdata_reg <= {29'h00000000, powerup_request_reg, cal_active,
          regulator_high_reg};
        default: prdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign prdata = rd ? prdata_reg : 32'h00000000;

  // ***********************************************************************
  // checks
  // ***********************************************************************
  sequence last_second_s;
    tick && seconds_of_day_counter_reg == `BRTC_SEC_MAX && !(wr && hit(`BRTC_OFF_TIME));
  endsequence

  sequence wrapped_s;
    ##1 seconds_of_day_counter_reg == 17'h00000;
  endsequence

  seconds_wrap_a: assert property (@(posedge clock) disable iff (!reset_n)
    last_second_s |-> wrapped_s) else $error("seconds did not wrap to zero");

  seconds_step_a: assert property (@(posedge clock) disable iff (!reset_n)
    tick && seconds_of_day_counter_reg < `BRTC_SEC_MAX && !(wr && hit(`BRTC_OFF_TIME))
    |=> seconds_of_day_counter_reg == $past(seconds_of_day_counter_reg) + 17'h00001)
    else $error("seconds did not step on tick");

  day_step_a: assert property (@(posedge clock) disable iff (!reset_n)
    last_second_s and !(wr && hit(`BRTC_OFF_DAY))
    |=> day_counter_reg == $past(day_counter_reg) + 15'h0001)
    else $error("day did not advance on rollover");

  second_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
    tick |=> irq_flag_reg[`BRTC_IRQ_SEC_BIT]) else $error("tick flag not set");

  alarm_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
    alarm_hit |=> irq_flag_reg[`BRTC_IRQ_ALM_BIT]) else $error("alarm flag not set");

  wake_request_a: assert property (@(posedge clock) disable iff (!reset_n)
    alarm_hit && power_mode != brtc_pkg::BRTC_PWR_ON |=> powerup_request)
    else $error("alarm did not request power-up");

  frozen_clock_a: assert property (@(posedge clock) disable iff (!reset_n)
    clock_disable_bit_reg && !wr |=> $stable(seconds_of_day_counter_reg)
    && $stable(day_counter_reg) && !tick) else $error("counters moved while disabled");

  flag_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    irq_flag_reg[`BRTC_IRQ_RST_BIT] && !(wr && hit(`BRTC_OFF_IRQ_STAT))
    |=> irq_flag_reg[`BRTC_IRQ_RST_BIT]) else $error("flag dropped without clear");

  mask_line_a: assert property (@(posedge clock) disable iff (!reset_n)
    (irq_flag_reg[`BRTC_IRQ_ALM_BIT] && !irq_mask_reg[`BRTC_IRQ_ALM_BIT] |-> irq)
    and (&irq_mask_reg |-> !irq)) else $error("interrupt line wrong");

  coin_no_cal_a: assert property (@(posedge clock) disable iff (!reset_n)
    calibration_mode_field_reg == brtc_pkg::BRTC_CAL_NOT_COIN
    && power_mode == brtc_pkg::BRTC_PWR_COIN |-> !cal_active)
    else $error("calibration active on coin cell");

  regulator_on_a: assert property (@(posedge clock) disable iff (!reset_n)
    backup_domain_regulator_en) else $error("regulator disabled");

endmodule

//--- core/brtc_defs.svh
/*
  holds the offsets, field positions, reset values and timing counts of the backed-up
  real time clock. assumes it is included by bare name from the design and bench files.
*/
`ifndef BRTC_DEFS_SVH
`define BRTC_DEFS_SVH

// ***********************************************************************
// register offsets
// ***********************************************************************
`define BRTC_OFF_CTRL 12'h000
`define BRTC_OFF_TIME 12'h004
`define BRTC_OFF_DAY 12'h008
`define BRTC_OFF_ALM_TIME 12'h00C
`define BRTC_OFF_ALM_DAY 12'h010
`define BRTC_OFF_IRQ_STAT 12'h014
`define BRTC_OFF_IRQ_MASK 12'h018
`define BRTC_OFF_STATUS 12'h01C

// ***********************************************************************
// field positions and reset values
// ***********************************************************************
`define BRTC_CTRL_DIS_BIT 0
`define BRTC_CTRL_CAL_LSB 8
`define BRTC_CTRL_MODE_LSB 16
`define BRTC_IRQ_SEC_BIT 0
`define BRTC_IRQ_ALM_BIT 1
`define BRTC_IRQ_RST_BIT 2
`define BRTC_MASK_RESET 3'h7
`define BRTC_STAT_INIT 3'h4

// ***********************************************************************
// timing counts
// ***********************************************************************
`define BRTC_BASE_CYCLES 32768
`define BRTC_SEC_MAX 17'h1517F
`define BRTC_DAY_MAX 15'h7FFF

`endif

//--- core/brtc_pkg.sv
/*
  types shared by the clock design files.
  assumes nothing beyond a systemverilog compiler.
*/
package brtc_pkg;

  // ***********************************************************************
  // calibration mode encoding
  // ***********************************************************************
  typedef enum logic [1:0] {
    BRTC_CAL_OFF = 2'h0,
    BRTC_CAL_NOT_COIN = 2'h1,
    BRTC_CAL_RESERVED = 2'h2,
    BRTC_CAL_ALWAYS = 2'h3
  } brtc_cal_mode_t;

  // ***********************************************************************
  // power mode of the device
  // ***********************************************************************
  typedef enum logic [1:0] {
    BRTC_PWR_ON = 2'h0,
    BRTC_PWR_OFF = 2'h1,
    BRTC_PWR_COIN = 2'h2
  } brtc_pwr_t;

endpackage

//--- core/brtc_divider.sv
/*
  divides the time base to a one-cycle tick per second with signed trim.
  assumes its clock is the 32.768 kHz time base and reset is the backup reset.
*/
`timescale 1ns/1ns
`include "brtc_defs.svh"

module brtc_divider #(
  parameter int CYCLES = `BRTC_BASE_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic run,
  input wire logic cal_active,
  input wire logic [4:0] calibration_word,
  output logic tick
);

  logic [16:0] count_reg;
  logic [16:0] terminal;

  // signed trim once per period; oscillator itself is never touched
  always_comb begin
    if (cal_active) begin
      terminal = 17'(CYCLES - 1 + int'($signed(calibration_word)));
    end else begin
      terminal = 17'(CYCLES - 1);
    end
  end

  // period counter, frozen while the clock is disabled
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 17'h00000;
    end else if (run) begin
      if (count_reg >= terminal) begin
        count_reg <= 17'h00000;
      end else begin
        count_reg <= count_reg + 17'h00001;
      end
    end
  end

  assign tick = run && (count_reg >= terminal);

  // every tick restarts the period, so no second tick can follow at once
  period_restart_a: assert property (@(posedge clock) disable iff (!reset_n)
    tick |=> count_reg == 17'h00000 && !tick) else $error("period did not restart after tick");

endmodule

//--- bench/brtc_host.sv
/*
  host processor model: an apb master that reaches the clock registers.
  assumes the bench calls its transfer task and that the slave shares its clock.
*/
`timescale 1ns/1ns

module brtc_host (
  input wire logic clock,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ***********************************************************************
  // idle bus
  // ***********************************************************************
  // bus starts idle so nothing is requested during reset
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end

  // ***********************************************************************
  // one transfer
  // ***********************************************************************
  // request held until pready is seen high; calibration words go out here
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // no wait limit here: only the bench watchdog may end a hung access
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // released data must not keep looking valid
  endtask
endmodule

//--- bench/brtc_top_bench.sv
/*
  self-checking bench of the backed-up clock: reset check, table of trim and regulator cases,
  then rollover, alarm, mask, disable, refusal and second reset tests.
  assumes the design files and brtc_host are compiled before it.
*/
`timescale 1ns/1ns
`include "brtc_defs.svh"

`define CHECK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end

module brtc_top_bench;
  localparam int CYC = 40; // short second keeps the run brief
  typedef struct {
    logic [3:0] strap;
    brtc_pkg::brtc_pwr_t pm;
    logic [1:0] cm;
    logic [4:0] cw;
    logic high;
    int period;
  } brtc_row_t;
  brtc_row_t rows[11] = '{
    '{4'h6, brtc_pkg::BRTC_PWR_ON, 2'h3, 5'h0F, 1'b1, 55},
    '{4'h7, brtc_pkg::BRTC_PWR_OFF, 2'h3, 5'h03, 1'b0, 43},
    '{4'h8, brtc_pkg::BRTC_PWR_ON, 2'h3, 5'h01, 1'b1, 41},
    '{4'h9, brtc_pkg::BRTC_PWR_COIN, 2'h3, 5'h1F, 1'b0, 39},
    '{4'h5, brtc_pkg::BRTC_PWR_ON, 2'h3, 5'h1D, 1'b0, 37},
    '{4'hA, brtc_pkg::BRTC_PWR_ON, 2'h3, 5'h11, 1'b0, 25},
    '{4'h9, brtc_pkg::BRTC_PWR_ON, 2'h3, 5'h10, 1'b1, 24},
    '{4'h6, brtc_pkg::BRTC_PWR_COIN, 2'h1, 5'h0F, 1'b0, 40},
    '{4'h0, brtc_pkg::BRTC_PWR_OFF, 2'h1, 5'h03, 1'b0, 43},
    '{4'hF, brtc_pkg::BRTC_PWR_ON, 2'h2, 5'h03, 1'b0, 40},
    '{4'h8, brtc_pkg::BRTC_PWR_ON, 2'h0, 5'h0F, 1'b1, 40}};
  logic [11:0] reset_addr[7] = '{`BRTC_OFF_IRQ_STAT, `BRTC_OFF_IRQ_MASK, `BRTC_OFF_CTRL,
    `BRTC_OFF_TIME, `BRTC_OFF_DAY, `BRTC_OFF_ALM_TIME, `BRTC_OFF_ALM_DAY};
  logic [31:0] reset_val[7] = '{32'h4, 32'h7, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, irq_d, rerr;
  logic slow_in = 1'b0;
  logic slow_out, pup, reg_en, reg_high;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, t0;
  logic [3:0] strap = 4'h0;
  brtc_pkg::brtc_pwr_t pmode = brtc_pkg::BRTC_PWR_ON;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  int last_rise = 0;
  int gap = 0;

  // ***********************************************************************
  // clock, slow clock and tick spacing
  // ***********************************************************************
  always #5 clock = ~clock;

  // gap between irq rises measures the trimmed second
  always @(posedge clock) begin
    slow_in <= ~slow_in;
    irq_d <= irq;
    cyc <= cyc + 1;
    if (irq === 1'b1 && irq_d !== 1'b1) begin
      gap <= cyc - last_rise;
      last_rise <= cyc;
    end
  end

  brtc_top #(.CYCLES(CYC)) dut (.clock(clock), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .powerup_strap_code(strap), .power_mode(pmode),
    .slow_clock_in(slow_in), .slow_clock_output(slow_out), .irq(irq),
    .powerup_request(pup), .backup_domain_regulator_en(reg_en),
    .backup_domain_regulator_high(reg_high));

  brtc_host host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ***********************************************************************
  // helpers
  // ***********************************************************************
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] junk;
    logic e;
    host.xfer(1'b1, a, d, junk, e);
  endtask

  task automatic rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0, rdat, rerr);
  endtask

  // waits for the unmasked second flag, then clears it
  task automatic wait_tick();
    int n;
    n = 0;
    @(posedge clock);
    while (irq !== 1'b1 && n < 4 * CYC) begin
      n++;
      @(posedge clock);
    end
    `CHECK(irq, 1'b1)
    wr(`BRTC_OFF_IRQ_STAT, 32'h1);
  endtask

  // reset values of every register except the status word, read right after release
  task automatic reset_check();
    for (int i = 0; i < 7; i++) begin
      rd(reset_addr[i]);
      `CHECK(rdat, reset_val[i])
    end
    `CHECK(irq, 1'b0)
    `CHECK(reg_en, 1'b1)
    `CHECK(pup, 1'b0)
    $display("test reset done");
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ***********************************************************************
  // watchdog
  // ***********************************************************************
  // about fifteen times the expected run
  initial begin
    #300000;
    bad_count++;
    final_report();
  end

  // ***********************************************************************
  // main sequence
  // ***********************************************************************
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    reset_check();
    wr(`BRTC_OFF_IRQ_MASK, 32'h6);
    // table: trim per mode and code, regulator level per strap and mode
    foreach (rows[i]) begin
      @(posedge clock);
      strap <= rows[i].strap;
      pmode <= rows[i].pm;
      wr(`BRTC_OFF_CTRL, {14'h0, rows[i].cm, 3'h0, rows[i].cw, 8'h0});
      repeat (3) wait_tick();
      `CHECK(gap, rows[i].period)
      `CHECK(reg_high, rows[i].high)
      `CHECK(reg_en, 1'b1)
      rd(`BRTC_OFF_STATUS);
      `CHECK(rdat[1:0], {rows[i].period != CYC, rows[i].high})
      #1;
      `CHECK(slow_out, slow_in)
    end
    $display("test table done");
    // rollover of seconds into days
    @(posedge clock);
    pmode <= brtc_pkg::BRTC_PWR_ON;
    wr(`BRTC_OFF_CTRL, 32'h0);
    wait_tick();
    wr(`BRTC_OFF_TIME, 32'h1517F);
    wr(`BRTC_OFF_DAY, 32'h5);
    wait_tick();
    rd(`BRTC_OFF_TIME);
    `CHECK(rdat, 32'h0)
    rd(`BRTC_OFF_DAY);
    `CHECK(rdat, 32'h6)
    wait_tick();
    rd(`BRTC_OFF_TIME);
    `CHECK(rdat, 32'h1)
    $display("test rollover done");
    // alarm: match when on, mismatch of day, match when off
    for (int i = 0; i < 3; i++) begin
      wait_tick();
      pmode <= (i == 0) ? brtc_pkg::BRTC_PWR_ON : brtc_pkg::BRTC_PWR_OFF;
      wr(`BRTC_OFF_ALM_TIME, 32'h64);
      wr(`BRTC_OFF_ALM_DAY, 32'h6);
      wr(`BRTC_OFF_DAY, (i == 1) ? 32'h7 : 32'h6);
      wr(`BRTC_OFF_TIME, 32'h64);
      wait_tick();
      rd(`BRTC_OFF_IRQ_STAT);
      `CHECK(rdat[1], (i != 1))
      `CHECK(pup, (i == 2))
      if (i < 2) begin
        wr(`BRTC_OFF_IRQ_STAT, 32'h2);
      end
    end
    pmode <= brtc_pkg::BRTC_PWR_ON;
    repeat (3) @(posedge clock);
    `CHECK(pup, 1'b0)
    $display("test alarm done");
    // latched alarm flag against its mask
    wr(`BRTC_OFF_IRQ_MASK, 32'h7);
    #1;
    `CHECK(irq, 1'b0)
    rd(`BRTC_OFF_IRQ_STAT);
    `CHECK(rdat[1], 1'b1)
    wr(`BRTC_OFF_IRQ_MASK, 32'h5);
    #1;
    `CHECK(irq, 1'b1)
    wr(`BRTC_OFF_IRQ_STAT, 32'h2);
    #1;
    `CHECK(irq, 1'b0)
    wr(`BRTC_OFF_IRQ_STAT, 32'h4);
    rd(`BRTC_OFF_IRQ_STAT);
    `CHECK(rdat[2], 1'b0)
    $display("test mask done");
    // disable freezes time and keeps the second flag quiet
    wr(`BRTC_OFF_CTRL, 32'h1);
    wr(`BRTC_OFF_IRQ_STAT, 32'h1);
    rd(`BRTC_OFF_TIME);
    t0 = rdat;
    repeat (3 * CYC) @(posedge clock);
    rd(`BRTC_OFF_TIME);
    `CHECK(rdat, t0)
    rd(`BRTC_OFF_IRQ_STAT);
    `CHECK(rdat[0], 1'b0)
    wr(`BRTC_OFF_CTRL, 32'h0);
    $display("test disable done");
    // unmapped and unaligned places are refused
    for (int i = 0; i < 2; i++) begin
      rd((i == 0) ? 12'h020 : 12'h006);
      `CHECK(rerr, 1'b1)
      `CHECK(rdat, 32'h0)
    end
    $display("test refusal done");
    // second reset in mid-run loads the reset values again
    wr(`BRTC_OFF_ALM_TIME, 32'h9);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    reset_check();
    final_report();
  end
endmodule
